// ===== include/adcf_pkg.sv
// adcf_pkg: constants shared by the converter result and control logic.
// assumes a byte-wide register port with 3-bit addresses and a 25 MHz clock.
package adcf_pkg;

  // ==========================================================================
  // register map (byte offsets on the plain register port)
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_CHAN   = 3'h1;
  localparam logic [2:0] ADDR_RES_HI = 3'h2;
  localparam logic [2:0] ADDR_RES_LO = 3'h3;
  localparam logic [2:0] ADDR_STAT   = 3'h4;
  localparam logic [2:0] ADDR_MASK   = 3'h5;

  // ==========================================================================
  // control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_GO     = 1;
  localparam int CTRL_FMT    = 2;
  localparam int CTRL_REFEXT = 3;
  localparam int CTRL_DIFF   = 4;
  localparam int CTRL_WMODE  = 5;
  localparam logic [7:0] CTRL_WR_MASK = 8'h3d;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [3:0] CHAN_RESET   = 4'h0;

  // ==========================================================================
  // interrupt status / mask fields
  localparam int EVT_DONE = 0;
  localparam int EVT_LOST = 1;
  localparam int EVT_W    = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

  // ==========================================================================
  // conversion geometry
  localparam int MAG_W = 12;
  localparam int RAW_W = 13;
  localparam int RES_W = 16;
  localparam int FMT_PAD = 3;
  localparam logic [MAG_W-1:0] MAG_MSB    = 12'h800;
  localparam logic [MAG_W-1:0] LAST_FULL  = 12'h001;
  localparam logic [MAG_W-1:0] LAST_SHORT = 12'h004;
  localparam logic [MAG_W-1:0] MAG_ZERO   = 12'h000;

  // ==========================================================================
  // timing: acquisition time before the first trial
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACQ_TIME_NS   = 400;
  localparam int ACQ_CYC_I     = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC       = (ACQ_CYC_I < 1) ? 1 : ACQ_CYC_I;
  localparam logic [7:0] ACQ_LOAD = 8'(ACQ_CYC - 1);
  localparam logic [7:0] CNT_ZERO = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SAMP  = 5'b00010,
    ST_SIGN  = 5'b00100,
    ST_TRIAL = 5'b01000,
    ST_LOAD  = 5'b10000
  } adcf_state_e;

endpackage

// ===== design/adcf_top.sv
// adcf_top: successive-approximation sequencer, result formatting,
// reference/input selection, completion interrupt and wake request.
// assumes the comparator and trial dac are outside and settle in one clock;
// inputs other than rst_b are synchronous to clk.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// - successive approximation builds a 12-bit magnitude, stored in the result byte pair.
// - a finished conversion raises the completion interrupt.
// - the completion interrupt also requests wake-up while the device sleeps.
// - format zero: magnitude in bits 15..4, bits 3..1 zero, sign in bit 0.
// - format one: right-justified two's complement, sign-extended through upper bits.
// - raw 13-bit sign-magnitude is repacked with the sign in bit 0 or translated to two's complement.
// - software picks internal or external reference.
// - single-ended or differential input; negative differential outcomes carry a sign.
module adcf_top (
  input  wire logic       clk,          // 25 MHz device clock
  input  wire logic       rst_b,        // asynchronous reset, active low
  input  wire logic [2:0] addr,         // register address
  input  wire logic [7:0] wdata,        // register write data
  input  wire logic       wr_en,        // write strobe
  input  wire logic       rd_en,        // read strobe
  input  wire logic       sleep_mode,   // device is in sleep
  input  wire logic       cmp_low,      // comparator: input below trial level
  output logic      [7:0] rdata,        // read data, cycle after rd_en
  output logic      [3:0] chan_sel,     // analog channel select
  output logic            ref_ext,      // 1: external reference
  output logic            diff_en,      // 1: differential input
  output logic            sample_en,    // sample-and-hold tracking
  output logic            mag_invert,   // swap front-end polarity after a negative sign
  output logic     [11:0] trial_code,   // trial level to the dac
  output logic            irq,          // level interrupt
  output logic            wake          // one-cycle wake request
);

  // ==========================================================================
  // helpers
  // sign-magnitude raw word to the selected 16-bit layout
  function automatic logic [15:0] fmt_result(input logic fmt,
                                             input logic [12:0] raw);
    logic [11:0] mag;
    logic [12:0] tc;
    mag = raw[11:0];
    tc  = {raw[12], (raw[12] ? 12'(~mag + 12'h001) : mag)};
    if (fmt) begin
      fmt_result = {{(adcf_pkg::RES_W - adcf_pkg::RAW_W){tc[12]}}, tc};
    end else begin
      fmt_result = {mag, {adcf_pkg::FMT_PAD{1'b0}}, raw[12]};
    end
  endfunction

  // ==========================================================================
  // state
  adcf_pkg::adcf_state_e  state_ff, nxt_state;
  logic [7:0]             cnt_ff, nxt_cnt;
  logic [11:0]            code_ff, nxt_code;
  logic [11:0]            bit_ff, nxt_bit;
  logic                   sign_ff, nxt_sign;
  logic                   samp_ff, nxt_samp;
  logic                   done;

  logic [7:0]             ctrl_ff, nxt_ctrl;
  logic [3:0]             chan_ff, nxt_chan;
  logic [15:0]            res_ff, nxt_res;
  logic [1:0]             stat_ff, nxt_stat;
  logic [1:0]             mask_ff, nxt_mask;
  logic [7:0]             rdata_ff, nxt_rdata;
  logic                   irq_ff, nxt_irq;
  logic                   wake_ff, nxt_wake;

  logic                   go_req;
  logic                   busy;
  logic [11:0]            last_bit;

  assign busy     = (state_ff != adcf_pkg::ST_IDLE);
  assign go_req   = wr_en && (addr == adcf_pkg::ADDR_CTRL) && wdata[adcf_pkg::CTRL_GO]
                    && wdata[adcf_pkg::CTRL_ENABLE];
  // reduced width mode stops two trials early; the low bits stay zero
  assign last_bit = ctrl_ff[adcf_pkg::CTRL_WMODE] ? adcf_pkg::LAST_SHORT
                                                  : adcf_pkg::LAST_FULL;

  // ==========================================================================
  // conversion sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_code  = code_ff;
    nxt_bit   = bit_ff;
    nxt_sign  = sign_ff;
    nxt_samp  = 1'b0;
    done      = 1'b0;
    case (state_ff)
      adcf_pkg::ST_IDLE: begin
        if (go_req) begin
          nxt_state = adcf_pkg::ST_SAMP;
          nxt_cnt   = adcf_pkg::ACQ_LOAD;
          nxt_code  = adcf_pkg::MAG_ZERO;
          nxt_sign  = 1'b0;
          nxt_samp  = 1'b1;
        end
      end
      adcf_pkg::ST_SAMP: begin
        if (cnt_ff == adcf_pkg::CNT_ZERO) begin
          // single-ended inputs are never negative, so the sign trial is skipped
          if (ctrl_ff[adcf_pkg::CTRL_DIFF]) begin
            nxt_state = adcf_pkg::ST_SIGN;
          end else begin
            nxt_state = adcf_pkg::ST_TRIAL;
            nxt_code  = adcf_pkg::MAG_MSB;
            nxt_bit   = adcf_pkg::MAG_MSB;
          end
        end else begin
          nxt_cnt  = cnt_ff - 8'h01;
          nxt_samp = 1'b1;
        end
      end
      adcf_pkg::ST_SIGN: begin
        // zero trial level: a low comparator means a negative differential input
        nxt_sign  = cmp_low;
        nxt_state = adcf_pkg::ST_TRIAL;
        nxt_code  = adcf_pkg::MAG_MSB;
        nxt_bit   = adcf_pkg::MAG_MSB;
      end
      adcf_pkg::ST_TRIAL: begin
        nxt_code = cmp_low ? (code_ff & ~bit_ff) : code_ff;
        if (bit_ff == last_bit) begin
          nxt_state = adcf_pkg::ST_LOAD;
        end else begin
          nxt_bit  = bit_ff >> 1;
          nxt_code = nxt_code | (bit_ff >> 1);
        end
      end
      adcf_pkg::ST_LOAD: begin
        done      = 1'b1;
        nxt_state = adcf_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = adcf_pkg::ST_IDLE;
      end
    endcase
    // clearing enable abandons a conversion in flight without a result
    if (!ctrl_ff[adcf_pkg::CTRL_ENABLE] && !go_req) begin
      nxt_state = adcf_pkg::ST_IDLE;
      nxt_samp  = 1'b0;
      done      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= adcf_pkg::ST_IDLE;
      cnt_ff   <= adcf_pkg::CNT_ZERO;
      code_ff  <= adcf_pkg::MAG_ZERO;
      bit_ff   <= adcf_pkg::MAG_ZERO;
      sign_ff  <= 1'b0;
      samp_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      code_ff  <= nxt_code;
      bit_ff   <= nxt_bit;
      sign_ff  <= nxt_sign;
      samp_ff  <= nxt_samp;
    end
  end

  // ==========================================================================
  // registers, result, interrupt
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_chan  = chan_ff;
    nxt_res   = res_ff;
    nxt_mask  = mask_ff;
    nxt_stat  = stat_ff;
    nxt_rdata = 8'h00;
    if (wr_en) begin
      case (addr)
        adcf_pkg::ADDR_CTRL: begin
          nxt_ctrl = wdata & adcf_pkg::CTRL_WR_MASK;
        end
        adcf_pkg::ADDR_CHAN: begin
          nxt_chan = wdata[3:0];
        end
        adcf_pkg::ADDR_STAT: begin
          nxt_stat = stat_ff & ~wdata[adcf_pkg::EVT_W-1:0];
        end
        adcf_pkg::ADDR_MASK: begin
          nxt_mask = wdata[adcf_pkg::EVT_W-1:0];
        end
        default: begin
          nxt_mask = mask_ff;
        end
      endcase
    end
    // format bit is sampled at the end of the conversion
    if (done) begin
      nxt_res = fmt_result(ctrl_ff[adcf_pkg::CTRL_FMT], {sign_ff, code_ff});
    end
    // event set wins over a write-one clear in the same cycle
    nxt_stat[adcf_pkg::EVT_DONE] = nxt_stat[adcf_pkg::EVT_DONE] | done;
    nxt_stat[adcf_pkg::EVT_LOST] = nxt_stat[adcf_pkg::EVT_LOST] | (go_req && busy);
    if (rd_en) begin
      case (addr)
        adcf_pkg::ADDR_CTRL: begin
          nxt_rdata = {ctrl_ff[7:2], busy, ctrl_ff[0]};
        end
        adcf_pkg::ADDR_CHAN: begin
          nxt_rdata = {4'h0, chan_ff};
        end
        adcf_pkg::ADDR_RES_HI: begin
          nxt_rdata = res_ff[15:8];
        end
        adcf_pkg::ADDR_RES_LO: begin
          nxt_rdata = res_ff[7:0];
        end
        adcf_pkg::ADDR_STAT: begin
          nxt_rdata = {6'h00, stat_ff};
        end
        adcf_pkg::ADDR_MASK: begin
          nxt_rdata = {6'h00, mask_ff};
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
    nxt_irq  = |(nxt_stat & nxt_mask);
    // wake only for an enabled completion that lands while asleep
    nxt_wake = done && sleep_mode && nxt_mask[adcf_pkg::EVT_DONE];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff  <= adcf_pkg::CTRL_RESET;
      chan_ff  <= adcf_pkg::CHAN_RESET;
      res_ff   <= 16'h0000;
      stat_ff  <= adcf_pkg::EVT_RESET;
      mask_ff  <= adcf_pkg::EVT_RESET;
      rdata_ff <= 8'h00;
      irq_ff   <= 1'b0;
      wake_ff  <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      chan_ff  <= nxt_chan;
      res_ff   <= nxt_res;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
      wake_ff  <= nxt_wake;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign rdata      = rdata_ff;
  assign chan_sel   = chan_ff;
  assign ref_ext    = ctrl_ff[adcf_pkg::CTRL_REFEXT];
  assign diff_en    = ctrl_ff[adcf_pkg::CTRL_DIFF];
  assign sample_en  = samp_ff;
  assign mag_invert = sign_ff;
  assign trial_code = code_ff;
  assign irq        = irq_ff;
  assign wake       = wake_ff;

endmodule // adcf_top

// ===== tb/adcf_top_sva.sv
// port checker for adcf_top
// assumes one clock domain; bound to every adcf_top below
`timescale 1ns/10ps
module adcf_chk (
  input wire logic        clk,        // clock
  input wire logic        rst_b,      // reset
  input wire logic [2:0]  addr,       // address
  input wire logic [7:0]  wdata,      // write data
  input wire logic        wr_en,      // write
  input wire logic        rd_en,      // read
  input wire logic        sleep_mode, // asleep
  input wire logic [7:0]  rdata,      // read data
  input wire logic [3:0]  chan_sel,   // channel
  input wire logic        ref_ext,    // reference
  input wire logic        diff_en,    // differential
  input wire logic        sample_en,  // acquiring
  input wire logic [11:0] trial_code, // trial
  input wire logic        irq,        // interrupt
  input wire logic        wake        // wake
);
  // ==========
  // shadow bits rebuilt from bus writes
  logic m0_ff, nxt_m0, wm_ff, nxt_wm, en_ff, nxt_en;
  always_comb begin
    nxt_m0 = (wr_en && addr == adcf_pkg::ADDR_MASK) ? wdata[0] : m0_ff;
    nxt_wm = (wr_en && addr == adcf_pkg::ADDR_CTRL) ? wdata[5] : wm_ff;
    nxt_en = (wr_en && addr == adcf_pkg::ADDR_CTRL) ? wdata[adcf_pkg::CTRL_ENABLE] : en_ff;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m0_ff <= 1'b0;
      wm_ff <= 1'b0;
      en_ff <= 1'b0;
    end else begin
      m0_ff <= nxt_m0;
      wm_ff <= nxt_wm;
      en_ff <= nxt_en;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence acq_s;
    sample_en [*8] ##1 sample_en [*2] ##1 !sample_en;
  endsequence
  // irq low beforehand so its rise marks this completion
  sequence go_s;
    $rose(sample_en) && !wm_ff && m0_ff && !irq;
  endsequence
  // clearing enable legally abandons a conversion, so the timing checks stand down then
  chk_acq_len: assert property (disable iff (!rst_b || !en_ff) $rose(sample_en) |-> acq_s)
    else $error("acquisition length wrong");
  chk_first_trial: assert property (disable iff (!rst_b || !en_ff)
    $fell(sample_en) && !diff_en |-> trial_code == 12'h800)
    else $error("first trial not msb");
  chk_sign_step: assert property (disable iff (!rst_b || !en_ff)
    $fell(sample_en) && diff_en |-> trial_code == 12'h000 ##1 trial_code == 12'h800)
    else $error("sign step missing");
  chk_done_se: assert property (disable iff (!rst_b || !en_ff)
    go_s ##0 !diff_en |-> ##22 !irq ##1 irq)
    else $error("completion time wrong");
  chk_done_diff: assert property (disable iff (!rst_b || !en_ff)
    go_s ##0 diff_en |-> ##23 !irq ##1 irq)
    else $error("differential completion time wrong");
  chk_rd_quiet: assert property (!$past(rd_en) || $past(addr) > 3'h5 |-> rdata == 8'h00)
    else $error("read data not quiet");
  chk_ref_out: assert property (wr_en && addr == adcf_pkg::ADDR_CTRL |=>
    ref_ext == $past(wdata[3]) && diff_en == $past(wdata[4]))
    else $error("reference or input select wrong");
  chk_chan_out: assert property (wr_en && addr == adcf_pkg::ADDR_CHAN |=>
    chan_sel == $past(wdata[3:0]))
    else $error("channel select wrong");
  chk_wake_cause: assert property (wake |-> $past(sleep_mode) && irq && m0_ff ##1 !wake)
    else $error("wake without cause");
endmodule // adcf_chk

bind adcf_top adcf_chk u_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .sleep_mode(sleep_mode), .rdata(rdata),
  .chan_sel(chan_sel), .ref_ext(ref_ext), .diff_en(diff_en), .sample_en(sample_en),
  .trial_code(trial_code), .irq(irq), .wake(wake));

// ===== tb/tb.sv
// self-checking bench for adcf_top: formats, registers, wake
// assumes the checker is bound; the comparator is modelled inline
`timescale 1ns/10ps
module tb;
  logic        clk, rst_b, wr_en, rd_en, sleep_mode, cmp_low, neg_in, wm_sel;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, hi, lo;
  logic [3:0]  chan_sel;
  logic        ref_ext, diff_en, sample_en, mag_invert, irq, wake;
  logic [11:0] trial_code, mag_in;
  int          error_cnt, checked, wake_cnt;
  // sign and magnitude in, then sign-magnitude and two's complement words
  logic [12:0] tv_in [7] = '{13'h0fff, 13'h0933, 13'h0001, 13'h0000, 13'h1001, 13'h1fff, 13'h1000};
  logic [15:0] tv_sm [7] = '{16'hfff0, 16'h9330, 16'h0010, 16'h0000, 16'h0011, 16'hfff1, 16'h0001};
  logic [15:0] tv_tc [7] = '{16'h0fff, 16'h0933, 16'h0001, 16'h0000, 16'hffff, 16'hf001, 16'hf000};

  adcf_top DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .sleep_mode(sleep_mode), .cmp_low(cmp_low), .rdata(rdata),
    .chan_sel(chan_sel), .ref_ext(ref_ext), .diff_en(diff_en), .sample_en(sample_en),
    .mag_invert(mag_invert), .trial_code(trial_code), .irq(irq), .wake(wake));

  // sign step shows trial zero; negative inputs only matter there
  assign cmp_low = (trial_code == 12'h000) ? neg_in : (mag_in < trial_code);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (wake === 1'b1) wake_cnt++;

  // ==========
  // shared tasks
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic convert(input logic f, input logic [12:0] v, input logic sl);
    int n;
    @(posedge clk);
    neg_in     <= v[12];
    mag_in     <= v[11:0];
    sleep_mode <= sl;
    wr(adcf_pkg::ADDR_CTRL, {2'b00, wm_sel, v[12], 1'b0, f, 2'b11});
    for (n = 0; n < 60 && irq !== 1'b1; n++) @(posedge clk);
    sleep_mode <= 1'b0;
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, mag_invert}, {15'h0000, v[12]});
    if (irq !== 1'b1) wrap_up();
  endtask

  // ==========
  // scenarios
  task automatic t_regs();
    int a;
    for (a = 0; a < 8; a++) begin
      rd(3'(a), hi);
      chk({8'h00, hi}, 16'h0000);
    end
    wr(3'h7, 8'hff);
    rd(3'h7, hi);
    chk({8'h00, hi}, 16'h0000);
    wr(adcf_pkg::ADDR_CHAN, 8'h0a);
    #1 chk({12'h000, chan_sel}, 16'h000a);
    wr(adcf_pkg::ADDR_CTRL, 8'h18);
    #1 chk({14'h0000, ref_ext, diff_en}, 16'h0003);
    wr(adcf_pkg::ADDR_CTRL, 8'h00);
    #1 chk({14'h0000, ref_ext, diff_en}, 16'h0000);
  endtask
  task automatic t_format();
    int i;
    int f;
    for (i = 0; i < 7; i++) begin
      for (f = 0; f < 2; f++) begin
        convert(f[0], tv_in[i], 1'b0);
        rd(adcf_pkg::ADDR_RES_HI, hi);
        rd(adcf_pkg::ADDR_RES_LO, lo);
        chk({hi, lo}, f ? tv_tc[i] : tv_sm[i]);
        wr(adcf_pkg::ADDR_STAT, 8'h01);
        rd(adcf_pkg::ADDR_STAT, hi);
        chk({7'h00, irq, hi}, 16'h0000);
      end
    end
    wr(adcf_pkg::ADDR_RES_HI, 8'h55);
    rd(adcf_pkg::ADDR_RES_HI, hi);
    chk({8'h00, hi}, 16'h00f0);
  endtask
  task automatic t_wake();
    wake_cnt = 0;
    convert(1'b0, tv_in[1], 1'b1);
    repeat (2) @(posedge clk);
    chk(16'(wake_cnt), 16'h0001);
    wr(adcf_pkg::ADDR_STAT, 8'h01);
    convert(1'b0, tv_in[1], 1'b0);
    repeat (2) @(posedge clk);
    chk(16'(wake_cnt), 16'h0001);
  endtask
  // short mode stops after bit 2, so the two lowest magnitude bits read zero
  task automatic t_width();
    wr(adcf_pkg::ADDR_STAT, 8'h03);
    wm_sel = 1'b1;
    convert(1'b0, tv_in[1], 1'b0);
    wm_sel = 1'b0;
    rd(adcf_pkg::ADDR_RES_HI, hi);
    rd(adcf_pkg::ADDR_RES_LO, lo);
    chk({hi, lo}, 16'h9300);
    wr(adcf_pkg::ADDR_STAT, 8'h01);
  endtask
  // a start while busy is refused and flagged; clearing enable abandons without a result
  task automatic t_busy();
    wr(adcf_pkg::ADDR_STAT, 8'h03);
    wr(adcf_pkg::ADDR_CTRL, 8'h03);
    wr(adcf_pkg::ADDR_CTRL, 8'h03);
    rd(adcf_pkg::ADDR_CTRL, hi);
    chk({8'h00, hi}, 16'h0003);
    wr(adcf_pkg::ADDR_CTRL, 8'h00);
    repeat (30) @(posedge clk);
    rd(adcf_pkg::ADDR_STAT, hi);
    chk({7'h00, irq, hi}, 16'h0002);
    wr(adcf_pkg::ADDR_STAT, 8'h02);
  endtask

  initial begin
    rst_b      = 1'b0;
    addr       = 3'h0;
    wdata      = 8'h00;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    sleep_mode = 1'b0;
    neg_in     = 1'b0;
    wm_sel     = 1'b0;
    mag_in     = 12'h000;
    error_cnt  = 0;
    checked    = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    wr(adcf_pkg::ADDR_MASK, 8'h01);
    t_format();
    t_wake();
    t_width();
    t_busy();
    wrap_up();
  end
endmodule // tb
